// ==== src/aea_pkg.sv ====
// shared constants and types of the apparent energy accumulator
package aea_pkg;

   localparam int PHASES = 3;

   // register byte addresses
   localparam logic [7:0] ADDR_THRESHOLD     = 8'h00;
   localparam logic [7:0] ADDR_ENERGY_A      = 8'h04;
   localparam logic [7:0] ADDR_ENERGY_B      = 8'h08;
   localparam logic [7:0] ADDR_ENERGY_C      = 8'h0c;
   localparam logic [7:0] ADDR_EVENT_FLAGS   = 8'h10;
   localparam logic [7:0] ADDR_EVENT_ENABLE  = 8'h14;
   localparam logic [7:0] ADDR_LINE_CYCLE    = 8'h18;
   localparam logic [7:0] ADDR_HALF_CYCLES   = 8'h1c;
   localparam logic [7:0] ADDR_ACCUM_CONFIG  = 8'h20;

   // field positions
   localparam int BIT_HALF_FULL      = 4;
   localparam int BIT_LINE_DONE      = 5;
   localparam int BIT_LINE_VA_ENABLE = 2;
   localparam int BIT_CROSS_SEL_LO   = 3;
   localparam int BIT_CLEAR_ON_READ  = 6;
   localparam int BIT_WIRING_LO      = 4;
   localparam int BIT_ENERGY_HALF    = 30;
   localparam int THRESHOLD_SHIFT    = 27;

   // reset values
   localparam logic [7:0]  RESET_THRESHOLD   = 8'h03;
   localparam logic [15:0] RESET_HALF_CYCLES = 16'hffff;

   // timing: the first stage runs at 1.024 MHz derived from the 200 MHz clock
   localparam int CLK_FREQ_KHZ = 200000;
   localparam int ACC_RATE_KHZ = 1024;

   typedef enum logic [1:0] {
      AEA_WIRE_DIRECT   = 2'b00,
      AEA_WIRE_A_MINUS_C = 2'b01,
      AEA_WIRE_NEG_SUM  = 2'b10,
      AEA_WIRE_NEG_A    = 2'b11
   } aea_wiring_type;

   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [7:0]  addr;
      logic [31:0] wdata;
   } aea_bus_req_type;

   typedef struct packed {
      logic [23:0] v_rms;
      logic [23:0] i_rms;
   } aea_rms_type;

endpackage

// ==== src/aea_wiring.sv ====
// per-phase apparent power with wiring-mode selection of the phase b voltage
`timescale 1ns/1ps
`default_nettype none
module aea_wiring (
   input  wire logic                         i_ref_clk,
   input  wire logic                         i_nrst,
   input  wire aea_pkg::aea_rms_type [2:0]   i_rms,
   input  wire logic [23:0]                  i_vac_rms,
   input  wire logic [23:0]                  i_vneg_sum_rms,
   input  wire aea_pkg::aea_wiring_type      i_wiring,
   output logic [31:0]                       o_power [3],
   output logic [23:0]                       o_phase_b_voltage_rms
);
   logic [23:0] vb;
   logic [23:0] ib;
   logic [47:0] prod [3];

   always_comb begin
      unique case (i_wiring)
         aea_pkg::AEA_WIRE_DIRECT:    vb = i_rms[1].v_rms;
         aea_pkg::AEA_WIRE_A_MINUS_C: vb = i_vac_rms;
         aea_pkg::AEA_WIRE_NEG_SUM:   vb = i_vneg_sum_rms;
         aea_pkg::AEA_WIRE_NEG_A:     vb = i_rms[0].v_rms;
      endcase
      // three-wire: phase b current is gone after the high-pass filter
      ib = (i_wiring == aea_pkg::AEA_WIRE_A_MINUS_C) ? 24'h000000 : i_rms[1].i_rms;
   end

   assign prod[0] = i_rms[0].v_rms * i_rms[0].i_rms;
   assign prod[1] = vb * ib;
   assign prod[2] = i_rms[2].v_rms * i_rms[2].i_rms;

   always_ff @(posedge i_ref_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         for (int p = 0; p < 3; p++) o_power[p] <= 32'h00000000;
      end else begin
         // keep the upper product bits; rms values are magnitudes so power is never negative
         for (int p = 0; p < 3; p++) o_power[p] <= prod[p][47:16];
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_phase_b_voltage_rms <= 24'h000000;
      end else begin
         o_phase_b_voltage_rms <= vb;
      end
   end
endmodule
`default_nettype wire

// ==== src/aea_phase_acc.sv ====
// two-stage energy accumulation of one phase
`timescale 1ns/1ps
`default_nettype none
module aea_phase_acc #(
   parameter int ACC_W = 40
) (
   input  wire logic        i_ref_clk,
   input  wire logic        i_nrst,
   input  wire logic        i_tick,
   input  wire logic [31:0] i_power,
   input  wire logic [7:0]  i_threshold,
   input  wire logic        i_clear,
   output logic [31:0]      o_count,
   output logic             o_pulse
);
   logic [ACC_W-1:0] acc;
   logic [ACC_W-1:0] sum;
   logic [ACC_W-1:0] thr;

   // one threshold formed from the 8-bit register over 27 zero bits
   assign thr = ACC_W'({i_threshold, 27'h0000000});
   assign sum = acc + ACC_W'(i_power);
   assign o_pulse = i_tick && (sum >= thr);

   always_ff @(posedge i_ref_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         acc <= '0;
      end else if (i_tick) begin
         // the same 8 kHz sample is added on every 1.024 MHz tick
         if (sum >= thr) begin
            acc <= sum - thr;
         end else begin
            acc <= sum;
         end
      end
   end

   // a pulse in the clearing cycle lands in the fresh count, so none is lost
   always_ff @(posedge i_ref_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_count <= 32'h00000000;
      end else begin
         o_count <= (i_clear ? 32'h00000000 : o_count) + {31'h00000000, o_pulse};
      end
   end
endmodule
`default_nettype wire

// ==== src/aea_top.sv ====
// apparent energy accumulator: tick, line-cycle control, registers, interrupt
`timescale 1ns/1ps
`default_nettype none
module aea_top #(
   parameter int CLK_KHZ  = aea_pkg::CLK_FREQ_KHZ,
   parameter int RATE_KHZ = aea_pkg::ACC_RATE_KHZ
) (
   input  wire logic                        i_ref_clk,
   input  wire logic                        i_nrst,
   input  wire aea_pkg::aea_bus_req_type    i_bus,
   output logic [31:0]                      o_rdata,
   input  wire aea_pkg::aea_rms_type [2:0]  i_rms,
   input  wire logic [23:0]                 i_vac_rms,
   input  wire logic [23:0]                 i_vneg_sum_rms,
   input  wire logic [2:0]                  i_zero_cross,
   output logic [23:0]                      o_phase_b_voltage_rms,
   output logic [2:0]                       o_energy_pulse,
   output logic                             o_interrupt_line_first_n
);
   localparam int TICK_W = 18;
   localparam logic [TICK_W-1:0] TICK_MOD  = TICK_W'(CLK_KHZ);
   localparam logic [TICK_W-1:0] TICK_STEP = TICK_W'(RATE_KHZ);

   logic [TICK_W-1:0] tick_phase;
   logic              tick;

   logic [7:0]  va_energy_threshold;
   logic [7:0]  event_enable_first;
   logic [7:0]  event_flags_first;
   logic [6:0]  line_cycle_config;
   logic [15:0] half_cycle_count;
   logic [1:0]  wiring_select;

   logic [15:0] half_cycles_left;
   logic        crossing_hit;
   logic        transfer;
   logic        line_va;
   logic        clear_on_read;

   logic [31:0] power [3];
   logic [31:0] count [3];
   logic [2:0]  clear_int;
   logic [2:0]  read_hit;
   logic [31:0] phase_va_energy [3];
   logic [2:0]  half_step;
   logic [7:0]  flag_set;
   logic [7:0]  flag_clr;

   assign line_va       = line_cycle_config[aea_pkg::BIT_LINE_VA_ENABLE];
   assign clear_on_read = line_cycle_config[aea_pkg::BIT_CLEAR_ON_READ];

   // fractional divider: 1.024 MHz is not an integer fraction of 200 MHz
   assign tick = (tick_phase + TICK_STEP) >= TICK_MOD;

   always_ff @(posedge i_ref_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         tick_phase <= '0;
      end else if (tick) begin
         tick_phase <= tick_phase + TICK_STEP - TICK_MOD;
      end else begin
         tick_phase <= tick_phase + TICK_STEP;
      end
   end

   aea_wiring u_wiring (
      .i_ref_clk             (i_ref_clk),
      .i_nrst                (i_nrst),
      .i_rms                 (i_rms),
      .i_vac_rms             (i_vac_rms),
      .i_vneg_sum_rms        (i_vneg_sum_rms),
      .i_wiring              (aea_pkg::aea_wiring_type'(wiring_select)),
      .o_power               (power),
      .o_phase_b_voltage_rms (o_phase_b_voltage_rms)
   );

   // ---- register writes
   always_ff @(posedge i_ref_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         va_energy_threshold <= aea_pkg::RESET_THRESHOLD;
         event_enable_first  <= 8'h00;
         line_cycle_config   <= 7'h00;
         half_cycle_count    <= aea_pkg::RESET_HALF_CYCLES;
         wiring_select       <= 2'h0;
      end else if (i_bus.wr) begin
         unique case (i_bus.addr)
            aea_pkg::ADDR_THRESHOLD:    va_energy_threshold <= i_bus.wdata[7:0];
            aea_pkg::ADDR_EVENT_ENABLE: event_enable_first  <= i_bus.wdata[7:0];
            aea_pkg::ADDR_LINE_CYCLE:   line_cycle_config   <= i_bus.wdata[6:0];
            aea_pkg::ADDR_HALF_CYCLES:  half_cycle_count    <= i_bus.wdata[15:0];
            aea_pkg::ADDR_ACCUM_CONFIG: wiring_select <= i_bus.wdata[aea_pkg::BIT_WIRING_LO +: 2];
            default: ;
         endcase
      end
   end

   // ---- half-cycle counting for line cycle mode
   // several phases crossing in one cycle count once; they are one edge apart in practice
   assign crossing_hit = |(i_zero_cross & line_cycle_config[aea_pkg::BIT_CROSS_SEL_LO +: 3]);
   assign transfer = line_va && crossing_hit && (half_cycles_left <= 16'h0001);

   always_ff @(posedge i_ref_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         half_cycles_left <= aea_pkg::RESET_HALF_CYCLES;
      end else if (!line_va || transfer) begin
         half_cycles_left <= half_cycle_count;
      end else if (crossing_hit) begin
         half_cycles_left <= half_cycles_left - 16'h0001;
      end
   end

   // ---- per-phase accumulation and visible energy registers
   generate
      for (genvar p = 0; p < aea_pkg::PHASES; p++) begin : g_phase
         assign read_hit[p] = i_bus.rd && (i_bus.addr == aea_pkg::ADDR_ENERGY_A + 8'(4 * p));
         // in line mode the counter restarts on transfer; the in-flight pulse stays counted
         assign clear_int[p] = transfer || (clear_on_read && read_hit[p]);

         aea_phase_acc u_acc (
            .i_ref_clk   (i_ref_clk),
            .i_nrst      (i_nrst),
            .i_tick      (tick),
            .i_power     (power[p]),
            .i_threshold (va_energy_threshold),
            .i_clear     (clear_int[p]),
            .o_count     (count[p]),
            .o_pulse     (o_energy_pulse[p])
         );

         always_ff @(posedge i_ref_clk or negedge i_nrst) begin
            if (!i_nrst) begin
               phase_va_energy[p] <= 32'h00000000;
            end else if (clear_on_read && read_hit[p]) begin
               phase_va_energy[p] <= 32'h00000000;
            end else if (!line_va || transfer) begin
               // the count is copied as is; its 32-bit add wraps 0xffffffff to 0x00000000
               phase_va_energy[p] <= count[p];
            end
         end

         assign half_step[p] = (!line_va || transfer) && !(clear_on_read && read_hit[p]) &&
                               (count[p][aea_pkg::BIT_ENERGY_HALF] !=
                                phase_va_energy[p][aea_pkg::BIT_ENERGY_HALF]);
      end
   endgenerate

   // ---- events and interrupt
   always_comb begin
      flag_set = 8'h00;
      flag_set[aea_pkg::BIT_HALF_FULL] = |half_step;
      flag_set[aea_pkg::BIT_LINE_DONE] = transfer;
      flag_clr = 8'h00;
      if (i_bus.wr && i_bus.addr == aea_pkg::ADDR_EVENT_FLAGS) begin
         flag_clr = i_bus.wdata[7:0];
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         event_flags_first <= 8'h00;
      end else begin
         // a new event in the clearing cycle wins
         event_flags_first <= (event_flags_first & ~flag_clr) | flag_set;
      end
   end

   assign o_interrupt_line_first_n = ~|(event_flags_first & event_enable_first);

   // ---- register reads, data in the following cycle only
   always_ff @(posedge i_ref_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_rdata <= 32'h00000000;
      end else if (!i_bus.rd) begin
         o_rdata <= 32'h00000000;
      end else begin
         unique case (i_bus.addr)
            aea_pkg::ADDR_THRESHOLD:    o_rdata <= {24'h000000, va_energy_threshold};
            // normal mode shows the live count: the copy happens at the access
            aea_pkg::ADDR_ENERGY_A:     o_rdata <= line_va ? phase_va_energy[0] : count[0];
            aea_pkg::ADDR_ENERGY_B:     o_rdata <= line_va ? phase_va_energy[1] : count[1];
            aea_pkg::ADDR_ENERGY_C:     o_rdata <= line_va ? phase_va_energy[2] : count[2];
            aea_pkg::ADDR_EVENT_FLAGS:  o_rdata <= {24'h000000, event_flags_first};
            aea_pkg::ADDR_EVENT_ENABLE: o_rdata <= {24'h000000, event_enable_first};
            aea_pkg::ADDR_LINE_CYCLE:   o_rdata <= {25'h0000000, line_cycle_config};
            aea_pkg::ADDR_HALF_CYCLES:  o_rdata <= {16'h0000, half_cycle_count};
            aea_pkg::ADDR_ACCUM_CONFIG: o_rdata <= {26'h0000000, wiring_select, 4'h0};
            default:                    o_rdata <= 32'h00000000;
         endcase
      end
   end
endmodule
`default_nettype wire

// ==== testbench/aea_host_model.sv ====
// host-side register master model for the apparent energy accumulator
`timescale 1ns/1ps
`default_nettype none
module aea_host_model (
   input  wire logic                    i_ref_clk,
   output var aea_pkg::aea_bus_req_type o_bus
);
   initial o_bus = '0;

   // each call holds one request across exactly one edge; idle drops the strobes
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] v;
      v = d;
      // a zero threshold would make the first stage pulse on every tick, so the host never sends one
      if (a == aea_pkg::ADDR_THRESHOLD && v[7:0] == 8'h00) v[7:0] = 8'h01;
      o_bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
      @(posedge i_ref_clk);
   endtask

   task automatic rd(input logic [7:0] a);
      o_bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
      @(posedge i_ref_clk);
   endtask

   task automatic idle();
      o_bus <= '0;
      @(posedge i_ref_clk);
   endtask
endmodule
`default_nettype wire

// ==== testbench/aea_top_properties.sv ====
// port checker of the apparent energy accumulator
`timescale 1ns/1ps
`default_nettype none
module aea_top_properties #(
   parameter int CLK_KHZ  = aea_pkg::CLK_FREQ_KHZ,
   parameter int RATE_KHZ = aea_pkg::ACC_RATE_KHZ
) (
   input wire logic                       i_ref_clk,
   input wire logic                       i_nrst,
   input wire aea_pkg::aea_bus_req_type   i_bus,
   input wire logic [31:0]                o_rdata,
   input wire aea_pkg::aea_rms_type [2:0] i_rms,
   input wire logic [23:0]                i_vac_rms,
   input wire logic [23:0]                i_vneg_sum_rms,
   input wire logic [2:0]                 i_zero_cross,
   input wire logic [23:0]                o_phase_b_voltage_rms,
   input wire logic [2:0]                 o_energy_pulse,
   input wire logic                       o_interrupt_line_first_n
);
   logic [1:0] en_sh;
   logic [1:0] wire_sh;

   default clocking @(posedge i_ref_clk); endclocking
   default disable iff (!i_nrst);

   // shadows of the enable and wiring fields, so outputs can be tied to them
   always_ff @(posedge i_ref_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         en_sh   <= 2'b00;
         wire_sh <= 2'b00;
      end else if (i_bus.wr) begin
         if (i_bus.addr == aea_pkg::ADDR_EVENT_ENABLE) en_sh <= i_bus.wdata[5:4];
         if (i_bus.addr == aea_pkg::ADDR_ACCUM_CONFIG) wire_sh <= i_bus.wdata[5:4];
      end
   end

   irq_needs_enable_a: assert property (!o_interrupt_line_first_n |-> en_sh != 2'b00)
      else $error("interrupt low with every event disabled");
   rdata_idle_a: assert property (!$past(i_bus.rd) |-> o_rdata == 32'h0)
      else $error("read data present without a read");
   unmapped_read_a: assert property (i_bus.rd && (i_bus.addr[1:0] != 2'b00
      || i_bus.addr > aea_pkg::ADDR_ACCUM_CONFIG) |=> o_rdata == 32'h0)
      else $error("unmapped read returned data");
   threshold_width_a: assert property (i_bus.rd && i_bus.addr == 8'h00
      |=> o_rdata[31:8] == 24'h0) else $error("threshold wider than eight bits");
   pulse_spacing_a: assert property ((2 * RATE_KHZ <= CLK_KHZ) && o_energy_pulse != 3'b000
      |=> o_energy_pulse == 3'b000) else $error("energy pulses on adjacent cycles");
   three_wire_b_a: assert property ((wire_sh == 2'b01) [*4] |-> !o_energy_pulse[1])
      else $error("phase b pulse in three-wire mode");
   b_line_voltage_a: assert property ((wire_sh == 2'b01) [*3]
      |-> o_phase_b_voltage_rms == $past(i_vac_rms)) else $error("phase b voltage not a-c");
   flag_clear_a: assert property (i_bus.wr && i_bus.addr == aea_pkg::ADDR_EVENT_FLAGS
      && i_bus.wdata[5:4] == 2'b11 && i_zero_cross == 3'b000 |=> o_interrupt_line_first_n)
      else $error("interrupt stayed low after flag clear");

   cover property (i_bus.rd ##1 o_rdata != 32'h0);
   cover property (o_energy_pulse[0]);
   cover property ($fell(o_interrupt_line_first_n));
endmodule

bind aea_top aea_top_properties #(.CLK_KHZ(CLK_KHZ), .RATE_KHZ(RATE_KHZ)) u_aea_top_properties (
   .i_ref_clk(i_ref_clk), .i_nrst(i_nrst), .i_bus(i_bus), .o_rdata(o_rdata), .i_rms(i_rms),
   .i_vac_rms(i_vac_rms), .i_vneg_sum_rms(i_vneg_sum_rms), .i_zero_cross(i_zero_cross),
   .o_phase_b_voltage_rms(o_phase_b_voltage_rms), .o_energy_pulse(o_energy_pulse),
   .o_interrupt_line_first_n(o_interrupt_line_first_n));
`default_nettype wire

// ==== testbench/aea_top_tb.sv ====
// self-checking bench of the apparent energy accumulator
`timescale 1ns/1ps
`default_nettype none
module aea_top_tb;
   localparam logic [7:0]  RA [8] = '{8'h00, 8'h10, 8'h14, 8'h18, 8'h1c, 8'h20, 8'h24, 8'h02};
   localparam logic [31:0] RV [8] = '{32'h3, 32'h0, 32'h0, 32'h0, 32'hffff, 32'h0, 32'h0, 32'h0};
   localparam int          THR [4] = '{1, 2, 3, 5};
   logic                       clk;
   logic                       nrst;
   aea_pkg::aea_bus_req_type   bus;
   logic [31:0]                rdata;
   aea_pkg::aea_rms_type [2:0] rms;
   logic [23:0]                vac;
   logic [23:0]                vneg;
   logic [2:0]                 zx;
   logic [23:0]                vb;
   logic [2:0]                 pulse;
   logic                       irq_n;
   logic [31:0]                expq[$];
   logic [31:0]                cnt[3];
   logic [31:0]                seed;
   logic                       cor;
   logic                       rd_q;
   int                         fail_count;
   int                         cmp_count;
   int                         n;

   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   // a tick every second cycle keeps the pulse spacing an exact figure
   aea_top #(.CLK_KHZ(2), .RATE_KHZ(1)) u_aea_top (.i_ref_clk(clk), .i_nrst(nrst), .i_bus(bus),
      .o_rdata(rdata), .i_rms(rms), .i_vac_rms(vac), .i_vneg_sum_rms(vneg), .i_zero_cross(zx),
      .o_phase_b_voltage_rms(vb), .o_energy_pulse(pulse), .o_interrupt_line_first_n(irq_n));
   aea_host_model u_aea_host_model (.i_ref_clk(clk), .o_bus(bus));

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   task automatic check(input string what, input logic [31:0] e, input logic [31:0] g);
      cmp_count++;
      if (g !== e) begin
         fail_count++;
         $display("Error %s expected %h seen %h", what, e, g);
      end
   endtask

   task automatic close_out();
      $display("compares %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   task automatic bw(input logic [7:0] a, input logic [31:0] d);
      u_aea_host_model.wr(a, d);
   endtask

   task automatic bi();
      u_aea_host_model.idle();
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      expq.push_back(e);
      u_aea_host_model.rd(a);
   endtask

   task automatic zc(input logic [2:0] m);
      zx <= m;
      @(posedge clk);
      zx <= 3'b000;
      repeat (3) @(posedge clk);
   endtask

   task automatic pulse_gap(output int t);
      t = 0;
      do begin
         @(posedge clk);
         t++;
      end while (pulse[0] !== 1'b1 && t < 600);
      if (t >= 600) begin
         fail_count++;
         close_out();
      end
   endtask

   task automatic line_pass(input logic [31:0] cfg, input logic [2:0] s, input logic [2:0] u);
      bw(8'h10, 32'h30);
      bw(8'h18, cfg);
      bi();
      n = 0;
      while (irq_n === 1'b1 && n < 8) begin
         zc(s);
         n++;
      end
      check("sync transfer", 32'h0, 32'(irq_n));
      bw(8'h10, 32'h30);
      bi();
      for (int i = 1; i <= 3; i++) begin
         zc(u);
         zc(s);
         check("line interrupt", 32'(i < 3), 32'(irq_n));
      end
   endtask

   // energy model: counts every pulse seen, restarts when a clearing read is taken
   always @(negedge clk) begin
      for (int k = 0; k < 3; k++) begin
         if (!nrst || (cor && bus.rd && bus.addr == 8'(4 * k + 4))) cnt[k] = 32'(pulse[k] & nrst);
         else cnt[k] = cnt[k] + 32'(pulse[k]);
      end
   end

   always @(posedge clk) begin
      if (rd_q === 1'b1) check("read data", expq.pop_front(), rdata);
      rd_q <= bus.rd;
   end

   initial begin
      fail_count = 0;
      cmp_count = 0;
      seed = 32'ha1e45956;
      {cor, zx, vac, vneg, nrst} = '0;
      rms[0] = {24'h100000, 24'h800000};
      rms[1] = rms[0];
      rms[2] = '0;
      repeat (8) @(posedge clk);
      nrst <= 1'b1;
      @(posedge clk);
      foreach (RA[i]) rd(RA[i], RV[i]);
      seed = lfsr(seed);
      bw(8'h1c, seed);
      rd(8'h1c, {16'h0, seed[15:0]});
      bw(8'h04, seed);
      rd(8'h04, cnt[0]);
      bw(8'h1c, 32'h3);
      bi();
      foreach (THR[i]) begin
         bw(8'h00, THR[i]);
         rd(8'h00, THR[i]);
         bi();
         repeat (5) pulse_gap(n);
         check("pulse gap", 32'(2 * THR[i]), 32'(n));
      end
      for (int c = 0; c < 2; c++) begin
         bw(8'h18, 32'(c) << 6);
         cor = (c == 1);
         repeat (2) for (int k = 0; k < 3; k++) rd(8'(4 * k + 4), cnt[k]);
         bi();
      end
      bw(8'h18, 32'h0);
      cor = 1'b0;
      for (int m = 0; m < 4; m++) begin
         seed = lfsr(seed);
         vac <= seed[23:0];
         vneg <= seed[31:8];
         rms[2] <= {seed[23:0], seed[31:8]};
         bw(8'h20, 32'(m) << 4);
         rd(8'h20, 32'(m) << 4);
         bi();
         repeat (3) @(posedge clk);
         check("phase b voltage", {8'h0, m == 0 ? rms[1].v_rms : m == 1 ? vac :
            m == 2 ? vneg : rms[0].v_rms}, {8'h0, vb});
         n = 0;
         repeat (40) begin
            @(posedge clk);
            n += int'(pulse[1] === 1'b1);
         end
         // direct wiring: one pulse every five ticks, so a 40-cycle window holds four
         if (m == 0) check("phase b pulses", 32'h4, 32'(n));
         if (m == 1) check("phase b pulses", 32'h0, 32'(n));
      end
      bw(8'h14, 32'h20);
      rd(8'h14, 32'h20);
      line_pass(32'h0c, 3'b001, 3'b110);
      bw(8'h10, 32'h0);
      rd(8'h10, 32'h20);
      bw(8'h14, 32'h0);
      bi();
      check("masked interrupt", 32'h1, 32'(irq_n));
      bw(8'h14, 32'h20);
      line_pass(32'h34, 3'b100, 3'b001);
      bi();
      repeat (4) @(posedge clk);
      close_out();
   end
endmodule
`default_nettype wire
